/* File: src/clear_exec_regs.vh */
// Constants for the clear-register and clear-watchdog instruction executor.
// Included by the executor and its phase sequencer; definitions only.
`ifndef CLEAR_EXEC_REGS_VH
`define CLEAR_EXEC_REGS_VH

// Opcode fields
`define CLR_REG_OPCODE      7'h35
`define CLR_REG_OPC_MSB     15
`define CLR_REG_OPC_LSB     9
`define ACCESS_SEL_BIT      8
`define ADDR_FIELD_MSB      7
`define ADDR_FIELD_LSB      0
`define CLR_WATCHDOG_WORD   16'h0004
`define CLEAR_VALUE         8'h00

// Addressing
`define INDEXED_LIMIT       8'h5F
`define ACCESS_LOW_BANK     4'h0
`define ACCESS_HIGH_BANK    4'hF
`define ACCESS_SPLIT        8'h60

// Reset values
`define ADDR_RESET          12'h000
`define FLAG_N_RESET        1'b1

// Four phases per instruction cycle
`define PHASE_Q1            2'h0
`define PHASE_Q2            2'h1
`define PHASE_Q3            2'h2
`define PHASE_Q4            2'h3

`endif

/* File: src/clear_file_and_watchdog_exec.v */
// Decode and execute for the clear-register and clear-watchdog instructions.
// Assumes the fetch stage presents a word valid at Q1, and that the data
// memory, status register and watchdog sit outside and obey the strobes.
// Summary of operation
// - A word whose top seven bits are 0110101 clears the addressed register and sets zero.
// - With the access selector at 0 the 8-bit address resolves inside the access bank.
// - With the access selector at 1 the bank select register supplies the upper address.
// - Selector 0, extended set on and address 95 or less switches to indexed literal offset.
// - The word 0x0004 clears the watchdog counter within one instruction cycle.
// - That same word clears the postscaler and sets the timeout and power-down flags to 1.
`timescale 1ns/1ps
`include "clear_exec_regs.vh"

module clear_file_and_watchdog_exec (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// Instruction fetch
	input  wire [15:0] instr_word,
	input  wire        instr_valid,
	// Core state
	input  wire [3:0]  bank_select_register,
	input  wire        extended_set_en,
	input  wire [11:0] index_base,
	// Data memory write port
	output reg  [11:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	output reg         mem_we,
	// Status register update
	output reg         zero_flag_set,
	output reg         timeout_flag_n,
	output reg         powerdown_flag_n,
	output reg         status_we,
	// Watchdog control
	output reg         watchdog_counter_clr,
	output reg         postscaler_clr,
	// Phase for the rest of the core
	output wire [1:0]  phase
);

	localparam ST_IDLE           = 2'h0;
	localparam ST_CLEAR_REG      = 2'h1;
	localparam ST_CLEAR_WATCHDOG = 2'h2;

	// Phase enables and opcode match
	wire        q1_en;
	wire        q3_en;
	wire        clear_register_op;
	wire        clear_watchdog_op;

	// Operand fields and the three candidate addresses
	wire        access_sel;
	wire [7:0]  field;
	wire        use_indexed;
	wire [11:0] access_addr;
	wire [11:0] banked_addr;
	wire [11:0] indexed_addr;

	// Decode state and next values of the registered outputs
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [11:0] next_addr;
	reg  [7:0]  next_mem_wdata;
	reg         next_mem_we;
	reg         next_zero_flag_set;
	reg         next_timeout_flag_n;
	reg         next_powerdown_flag_n;
	reg         next_status_we;
	reg         next_watchdog_counter_clr;
	reg         next_postscaler_clr;

	// Q4 enable is left open: strobes launch on the Q3 edge and stand through Q4
	phase_sequencer u_phase (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.phase   (phase),
		.q1_en   (q1_en),
		.q3_en   (q3_en),
		.q4_en   ()
	);

	// Opcode match
	assign clear_register_op =
		(instr_word[`CLR_REG_OPC_MSB:`CLR_REG_OPC_LSB] == `CLR_REG_OPCODE);
	assign clear_watchdog_op = (instr_word == `CLR_WATCHDOG_WORD);

	// Indexed mode only replaces the access bank; the sum wraps at 12 bits, so a
	// base near the top of memory folds the operand back into page zero.
	assign access_sel   = instr_word[`ACCESS_SEL_BIT];
	assign field        = instr_word[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
	assign use_indexed  = !access_sel && extended_set_en && (field <= `INDEXED_LIMIT);
	assign banked_addr  = {bank_select_register, field};
	assign indexed_addr = index_base + {4'h0, field};
	assign access_addr  = (field < `ACCESS_SPLIT) ?
		{`ACCESS_LOW_BANK, field} : {`ACCESS_HIGH_BANK, field};

	// Selector 1 always takes the bank register, whatever the extended set says
	always @* begin
		if (access_sel) begin
			next_addr = banked_addr;
		end else if (use_indexed) begin
			next_addr = indexed_addr;
		end else begin
			next_addr = access_addr;
		end
	end

	// Decode at Q1; a refused word or instr_valid low leaves the state idle
	always @* begin
		next_state = ST_IDLE;
		if (instr_valid && clear_register_op) begin
			next_state = ST_CLEAR_REG;
		end else if (instr_valid && clear_watchdog_op) begin
			next_state = ST_CLEAR_WATCHDOG;
		end
	end

	// Decode state
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
		end else if (q1_en) begin
			state <= next_state;
		end
	end

	// The address stands for the whole instruction cycle
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mem_addr <= `ADDR_RESET;
		end else if (q1_en) begin
			mem_addr <= next_addr;
		end
	end

	// Strobes are one clock wide; both kinds launch on the Q3 edge, so they
	// stand during Q4 and finish inside the instruction cycle.
	always @* begin
		next_mem_wdata     = mem_wdata;
		next_mem_we        = 1'b0;
		next_zero_flag_set = 1'b0;
		case (state)
			ST_IDLE: begin
				next_mem_we = 1'b0;
			end
			ST_CLEAR_REG: begin
				if (q3_en) begin
					next_mem_wdata     = `CLEAR_VALUE;
					next_mem_we        = 1'b1;
					next_zero_flag_set = 1'b1;
				end
			end
			default: begin
				next_mem_we = 1'b0;
			end
		endcase
	end

	// Counter and postscaler clear on the same edge, so no stale postscaler
	// count survives the watchdog clear
	always @* begin
		next_timeout_flag_n       = timeout_flag_n;
		next_powerdown_flag_n     = powerdown_flag_n;
		next_status_we            = 1'b0;
		next_watchdog_counter_clr = 1'b0;
		next_postscaler_clr       = 1'b0;
		case (state)
			ST_IDLE: begin
				next_status_we = 1'b0;
			end
			ST_CLEAR_WATCHDOG: begin
				if (q3_en) begin
					next_watchdog_counter_clr = 1'b1;
					next_postscaler_clr       = 1'b1;
					next_timeout_flag_n       = 1'b1;
					next_powerdown_flag_n     = 1'b1;
					next_status_we            = 1'b1;
				end
			end
			default: begin
				next_status_we = 1'b0;
			end
		endcase
	end

	// Data memory write port
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mem_wdata <= `CLEAR_VALUE;
			mem_we    <= 1'b0;
		end else begin
			mem_wdata <= next_mem_wdata;
			mem_we    <= next_mem_we;
		end
	end

	// Status register update; nothing in this block lowers the two flags
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			zero_flag_set    <= 1'b0;
			timeout_flag_n   <= `FLAG_N_RESET;
			powerdown_flag_n <= `FLAG_N_RESET;
			status_we        <= 1'b0;
		end else begin
			zero_flag_set    <= next_zero_flag_set;
			timeout_flag_n   <= next_timeout_flag_n;
			powerdown_flag_n <= next_powerdown_flag_n;
			status_we        <= next_status_we;
		end
	end

	// Watchdog control
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			watchdog_counter_clr <= 1'b0;
			postscaler_clr       <= 1'b0;
		end else begin
			watchdog_counter_clr <= next_watchdog_counter_clr;
			postscaler_clr       <= next_postscaler_clr;
		end
	end

endmodule // clear_file_and_watchdog_exec

/* File: src/phase_sequencer.v */
// Generates the phase count and the Q1, Q3 and Q4 enables of the instruction cycle.
// Assumes one system clock; each phase lasts one clock.
`timescale 1ns/1ps
`include "clear_exec_regs.vh"

module phase_sequencer (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       rstn,
	// Phase enables
	output reg  [1:0] phase,
	output wire       q1_en,
	output wire       q3_en,
	output wire       q4_en
);

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			phase <= `PHASE_Q1;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	assign q1_en = (phase == `PHASE_Q1);
	assign q3_en = (phase == `PHASE_Q3);
	assign q4_en = (phase == `PHASE_Q4);

endmodule // phase_sequencer

/* File: verif/clear_exec_chk_sva.sv */
// Checker for the clear-register and clear-watchdog executor.
// Sees only the executor ports; pulses land three edges after the take edge.
`timescale 1ns/1ps
module clear_exec_chk (
	// Control
	input wire        sys_clk, rstn, instr_valid, extended_set_en, mem_we, zero_flag_set,
	input wire        timeout_flag_n, powerdown_flag_n, status_we,
	input wire        watchdog_counter_clr, postscaler_clr,
	// Buses
	input wire [15:0] instr_word,
	input wire [3:0]  bank_select_register,
	input wire [11:0] index_base, mem_addr,
	input wire [7:0]  mem_wdata,
	input wire [1:0]  phase
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire       take = instr_valid && phase == 2'h0;
	wire [7:0] f    = instr_word[7:0];
	wire       clr  = take && instr_word[15:9] == 7'h35;
	wire       idx  = extended_set_en && f <= 8'h5f;
	a_clear_write: assert property (clr |-> ##3 mem_we && zero_flag_set && mem_wdata == 8'h00)
		else $error("clear write missing");
	a_pulse_phase: assert property (mem_we || status_we |-> phase == 2'h3)
		else $error("pulse outside last phase");
	a_access_addr: assert property (clr && !instr_word[8] && !idx |->
		##1 mem_addr == {($past(f) < 8'h60) ? 4'h0 : 4'hf, $past(f)})
		else $error("access bank address wrong");
	a_bank_addr: assert property (clr && instr_word[8] |->
		##1 mem_addr == {$past(bank_select_register), $past(f)})
		else $error("banked address wrong");
	a_indexed_addr: assert property (clr && !instr_word[8] && idx |->
		##1 mem_addr == $past(index_base) + {4'h0, $past(f)})
		else $error("indexed address wrong");
	a_watchdog_clear: assert property (take && instr_word == 16'h0004 |->
		##3 watchdog_counter_clr && postscaler_clr && !mem_we)
		else $error("watchdog clear missing");
	a_watchdog_flags: assert property (take && instr_word == 16'h0004 |->
		##3 status_we && timeout_flag_n && powerdown_flag_n)
		else $error("status flags not set");
	a_refused_quiet: assert property (take && !clr && instr_word != 16'h0004 |->
		##3 !mem_we && !status_we && !watchdog_counter_clr)
		else $error("refused word produced a strobe");
	c_clear: cover property (clr ##3 mem_we);
	c_idx: cover property (clr && idx);
	c_watchdog: cover property (watchdog_counter_clr);
	c_refused: cover property (take && !clr);
endmodule // clear_exec_chk
bind clear_file_and_watchdog_exec clear_exec_chk u_chk (.*);

/* File: verif/tb.sv */
// Directed bench for the clear-register and clear-watchdog executor.
// Drives words 1 ns after each edge; flags are bundled at the pulse phase.
`timescale 1ns/1ps
module tb;
	reg         sys_clk = 0, rstn = 0, instr_valid = 0, extended_set_en = 0;
	reg  [15:0] instr_word = 16'h0000;
	reg  [3:0]  bank_select_register = 4'h0;
	reg  [11:0] index_base = 12'h100;
	wire [11:0] mem_addr;
	wire [7:0]  mem_wdata;
	wire [1:0]  phase;
	wire        mem_we, zero_flag_set, timeout_flag_n, powerdown_flag_n, status_we;
	wire        watchdog_counter_clr, postscaler_clr;
	integer     mismatches = 0, checks = 0, i;
	clear_file_and_watchdog_exec u_clear_file_and_watchdog_exec (.*);
	always #50 sys_clk = ~sys_clk;
	task close_out;
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			mismatches = mismatches + 1;
		end
	endtask
	// k = {we, zero, status_we, watchdog_clr, post_clr, timeout_n, powerdown_n}
	// k[6] also gates the address check
	task op(input [15:0] w, input v, input [3:0] b, input e, input [11:0] a, input [6:0] k);
		for (i = 0; i < 8 && phase !== 2'h0; i = i + 1)
			@(posedge sys_clk) #1;
		if (phase !== 2'h0) begin
			mismatches = mismatches + 1;
			close_out;
		end
		instr_word = w;
		instr_valid = v;
		bank_select_register = b;
		extended_set_en = e;
		@(posedge sys_clk) #1;
		if (k[6])
			chk(mem_addr, a);
		repeat (2) @(posedge sys_clk);
		#1 chk({mem_we, zero_flag_set, status_we, watchdog_counter_clr, postscaler_clr,
			timeout_flag_n, powerdown_flag_n}, k);
		instr_valid = 0;
	endtask
	task t_access;
		op(16'h6a20, 1, 4'h5, 0, 12'h020, 7'h63);
		op(16'h6a60, 1, 4'h5, 0, 12'hf60, 7'h63);
	endtask
	task t_bank;
		op(16'h6b33, 1, 4'ha, 1, 12'ha33, 7'h63);
	endtask
	task t_indexed;
		op(16'h6a5f, 1, 4'h5, 1, 12'h15f, 7'h63);
		op(16'h6a60, 1, 4'h5, 1, 12'hf60, 7'h63);
		index_base = 12'h7f0;
		op(16'h6a20, 1, 4'h5, 1, 12'h810, 7'h63);
	endtask
	task t_refuse;
		op(16'h6a20, 0, 4'h0, 0, 12'h000, 7'h03);
		op(16'h6c20, 1, 4'h0, 0, 12'h000, 7'h03);
	endtask
	task t_watchdog;
		op(16'h0004, 1, 4'h0, 0, 12'h000, 7'h1f);
		op(16'h0005, 1, 4'h0, 0, 12'h000, 7'h03);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 rstn = 1;
		t_access;
		t_bank;
		t_indexed;
		t_refuse;
		t_watchdog;
		close_out;
	end
endmodule // tb
